// ===== hw/snp_pkg.sv
// Shared constants and types for the serial flash status and protect link.
`default_nettype none
package snp_pkg;
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_GETF = 8'h0F;
	localparam logic [7:0] CMD_SETF = 8'h1F;
	localparam logic [7:0] CMD_PROG = 8'h10;
	localparam logic [7:0] CMD_PROT = 8'h2A;
	localparam logic [7:0] CMD_ERASE = 8'hD8;
	localparam logic [7:0] FA_LOCK = 8'hA0;
	localparam logic [7:0] FA_CFG = 8'hB0;
	localparam logic [7:0] FA_STAT = 8'hC0;
	localparam logic [7:0] FA_THR = 8'h10;
	// Field positions inside feature bytes.
	localparam int LOCK_WD_BIT = 7;
	localparam int LOCK_LSB = 3;
	localparam int PRTE_BIT = 7;
	localparam int THR_LSB = 4;
	// Values after power-on.
	localparam logic [2:0] LOCK_RST = 3'h7;
	localparam logic LOCK_WD_RST = 1'b0;
	localparam logic PRTE_RST = 1'b0;
	localparam logic [3:0] THR_RST = 4'h1;
	localparam logic WEL_RST = 1'b0;
	// Block addressing: block number sits in row address bits 16:6.
	localparam int BLK_LSB = 6;
	localparam logic [3:0] PROT_TOP = 4'hF;
	// First locked block per lock code, 2048 meaning none.
	localparam logic [7:0][11:0] LOCK_BASE = {12'h000, 12'h400, 12'h600,
		12'h700, 12'h780, 12'h7C0, 12'h7E0, 12'h800};
	// Timing in core clock cycles of 8 ns.
	localparam int CLK_NS = 8;
	localparam int OP_BUSY_NS = 2000;
	localparam logic [8:0] OP_BUSY_CYC = 9'(OP_BUSY_NS / CLK_NS);
	localparam logic [3:0] HALF_CYC = 4'h8;
	// Host register map and command register fields.
	localparam logic [7:0] HR_CMD = 8'h00;
	localparam logic [7:0] HR_ROW = 8'h04;
	localparam logic [7:0] HR_STAT = 8'h08;
	localparam logic [7:0] HR_WP = 8'h0C;
	localparam int CMD_FA_LSB = 8;
	localparam int CMD_FD_LSB = 16;
	localparam int CMD_REP_LSB = 24;
	localparam logic WP_RST = 1'b1;
	typedef enum logic [1:0] {
		OPK_PROG = 2'h0,
		OPK_PROT = 2'h1,
		OPK_ERASE = 2'h3
	} snp_opk_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_SHIFT = 2'h1,
		H_END = 2'h3
	} snp_hst_t;
endpackage
`default_nettype wire

// ===== hw/snp_if.sv
// Serial link between the host controller and the flash status logic.
`timescale 1ns/1ps
`default_nettype none
interface snp_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic wp_n;
	modport dev (input sclk, cs_n, mosi, wp_n, output miso);
	modport host (output sclk, cs_n, mosi, wp_n, input miso);
endinterface
`default_nettype wire

// ===== hw/snp_dev.sv
// Flash side: feature table, status streaming, block lock and protection.
//
// Chosen here: the serial link interface to the feature registers.
`timescale 1ns/1ps
`default_nettype none
module snp_dev (
	input wire logic core_clk_in, // Core clock, 125 MHz.
	input wire logic rst_in, // Asynchronous power-on reset, high.
	snp_if.dev link, // Serial link to the host.
	input wire logic ecc_report_in, // Pulse: a page read ECC result.
	input wire logic [3:0] ecc_flips_in, // Corrected bit count.
	input wire logic ecc_uncorr_in, // Uncorrectable page.
	input wire logic array_fail_in, // Array reports failure at completion.
	output logic op_start_out, // Pulse: array operation begins.
	output logic [1:0] op_kind_out, // Kind of the started operation.
	output logic [10:0] op_block_out // Target block of the operation.
);
	logic [1:0] sclk_s, cs_s, mosi_s, wp_s;
	logic sclk_d, cs_d;
	logic [2:0] bit_cnt, byte_cnt, ocnt;
	logic [7:0] rx, opcode, faddr;
	logic [6:0] osh;
	logic [23:0] row;
	logic stream, miso;
	logic lock_wd, protection_enable, write_enable_latch, busy, pf, ef;
	logic [2:0] lock;
	logic [3:0] thr;
	logic [1:0] ecc;
	logic [127:0] prot;
	logic [8:0] op_cnt;
	logic op_fail;
	snp_pkg::snp_opk_t op_kind;
	logic [10:0] op_block;
	logic op_start;

	// Link inputs pass two flip-flops before any logic reads them.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_s <= 2'h0;
			cs_s <= 2'h3;
			mosi_s <= 2'h0;
			wp_s <= 2'h3;
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			sclk_s <= {sclk_s[0], link.sclk};
			cs_s <= {cs_s[0], link.cs_n};
			mosi_s <= {mosi_s[0], link.mosi};
			wp_s <= {wp_s[0], link.wp_n};
			sclk_d <= sclk_s[1];
			cs_d <= cs_s[1];
		end
	end

	// Edge and byte decoding of the incoming stream.
	wire sel = ~cs_s[1];
	wire rise = sel & sclk_s[1] & ~sclk_d;
	wire fall = sel & ~sclk_s[1] & sclk_d;
	wire cs_rise = cs_s[1] & ~cs_d;
	wire byte_done = rise & (bit_cnt == 3'h7);
	wire [7:0] rbyte = {rx[6:0], mosi_s[1]};
	wire is_byte0 = byte_done & (byte_cnt == 3'h0);
	wire setf = byte_done & (byte_cnt == 3'h2) & (opcode == snp_pkg::CMD_SETF)
		& ~busy;
	wire lock_frozen = lock_wd & ~wp_s[1];
	wire [10:0] blk = row[snp_pkg::BLK_LSB +: 11];
	wire locked = {1'b0, blk} >= snp_pkg::LOCK_BASE[lock];
	wire in_top = blk[10:7] == snp_pkg::PROT_TOP;
	wire is_prot = prot[blk[6:0]] & in_top;
	wire arr_cmd = (opcode == snp_pkg::CMD_PROG) | (opcode == snp_pkg::CMD_ERASE)
		| ((opcode == snp_pkg::CMD_PROT) & protection_enable);
	wire go = cs_rise & (byte_cnt == 3'h4) & arr_cmd & write_enable_latch & ~busy;
	wire refuse = locked | is_prot | ((opcode == snp_pkg::CMD_PROT) & ~in_top);
	wire done = busy & (op_cnt == 9'h001);
	wire [7:0] stat_byte = {2'h0, ecc, pf, ef, write_enable_latch, busy};
	wire [7:0] fv = (faddr == snp_pkg::FA_STAT) ? stat_byte :
		(faddr == snp_pkg::FA_LOCK) ? {lock_wd, 1'b0, lock, 3'h0} :
		(faddr == snp_pkg::FA_CFG) ? {protection_enable, 7'h00} :
		(faddr == snp_pkg::FA_THR) ? {thr, 4'h0} : 8'h00;

	// Frame counters, opcode, feature address and row address capture.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
			rx <= 8'h00;
			opcode <= 8'h00;
			faddr <= 8'h00;
			row <= 24'h000000;
		end else if (!sel) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
		end else if (rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx <= rbyte;
			if (byte_done && byte_cnt != 3'h7) begin
				byte_cnt <= byte_cnt + 3'h1;
			end
			if (is_byte0) begin
				opcode <= rbyte;
			end
			if (byte_done && byte_cnt == 3'h1) begin
				faddr <= rbyte;
			end
			if (byte_done && byte_cnt != 3'h0 && byte_cnt < 3'h4) begin
				row <= {row[15:0], rbyte};
			end
		end
	end

	// Feature read: the selected byte repeats, latched at each first bit.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stream <= 1'b0;
			ocnt <= 3'h0;
			osh <= 7'h00;
			miso <= 1'b0;
		end else if (!sel) begin
			stream <= 1'b0;
			ocnt <= 3'h0;
		end else begin
			if (byte_done && byte_cnt == 3'h1 && opcode == snp_pkg::CMD_GETF) begin
				stream <= 1'b1;
			end
			if (fall && stream) begin
				ocnt <= ocnt + 3'h1;
				if (ocnt == 3'h0) begin
					miso <= fv[7];
					osh <= fv[6:0];
				end else begin
					miso <= osh[6];
					osh <= {osh[5:0], 1'b0};
				end
			end
		end
	end

	// Feature table writes; reset commands never touch these bits.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lock <= snp_pkg::LOCK_RST;
			lock_wd <= snp_pkg::LOCK_WD_RST;
			protection_enable <= snp_pkg::PRTE_RST;
			thr <= snp_pkg::THR_RST;
		end else if (setf) begin
			if (faddr == snp_pkg::FA_LOCK && !lock_frozen) begin
				lock_wd <= rbyte[snp_pkg::LOCK_WD_BIT];
				lock <= rbyte[snp_pkg::LOCK_LSB +: 3];
			end
			if (faddr == snp_pkg::FA_CFG) begin
				protection_enable <= rbyte[snp_pkg::PRTE_BIT];
			end
			if (faddr == snp_pkg::FA_THR) begin
				thr <= rbyte[snp_pkg::THR_LSB +: 4];
			end
		end
	end

	// Write enable latch follows only its two commands and completion.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			write_enable_latch <= snp_pkg::WEL_RST;
		end else if (done) begin
			write_enable_latch <= 1'b0;
		end else if (is_byte0 && !busy && rbyte == snp_pkg::CMD_WREN) begin
			write_enable_latch <= 1'b1;
		end else if (is_byte0 && !busy && rbyte == snp_pkg::CMD_WRDI) begin
			write_enable_latch <= 1'b0;
		end
	end

	// Array operation sequencer: busy period, then pass or fail result.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy <= 1'b0;
			op_cnt <= 9'h000;
			op_fail <= 1'b0;
			op_kind <= snp_pkg::OPK_PROG;
			op_block <= 11'h000;
			op_start <= 1'b0;
		end else begin
			op_start <= go & ~refuse;
			if (go) begin
				busy <= 1'b1;
				op_cnt <= snp_pkg::OP_BUSY_CYC;
				op_fail <= refuse;
				op_block <= blk;
				op_kind <= (opcode == snp_pkg::CMD_PROG) ? snp_pkg::OPK_PROG :
					(opcode == snp_pkg::CMD_PROT) ? snp_pkg::OPK_PROT :
					snp_pkg::OPK_ERASE;
			end else if (busy) begin
				op_cnt <= op_cnt - 9'h001;
				busy <= ~done;
			end
		end
	end

	// Result flags, protected block store and ECC status.
	wire fail_now = op_fail | array_fail_in;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pf <= 1'b0;
			ef <= 1'b0;
			prot <= '0;
			ecc <= 2'h0;
		end else begin
			if (done && op_kind != snp_pkg::OPK_ERASE) begin
				pf <= fail_now;
			end
			if (done && op_kind == snp_pkg::OPK_ERASE) begin
				ef <= fail_now;
			end
			if (done && op_kind == snp_pkg::OPK_PROT && !fail_now) begin
				prot[op_block[6:0]] <= 1'b1;
			end
			if (ecc_report_in) begin
				ecc <= ecc_uncorr_in ? 2'h2 : (ecc_flips_in == 4'h0) ? 2'h0 :
					(ecc_flips_in >= thr) ? 2'h3 : 2'h1;
			end
		end
	end

	assign link.miso = miso;
	assign op_start_out = op_start;
	assign op_kind_out = op_kind;
	assign op_block_out = op_block;
endmodule // snp_dev
`default_nettype wire

// ===== hw/snp_host.sv
// Host side: AHB-Lite command registers driving the serial link.
`timescale 1ns/1ps
`default_nettype none
module snp_host (
	input wire logic core_clk_in, // Core clock, 125 MHz.
	input wire logic rst_in, // Asynchronous reset, high.
	input wire logic hsel_in, // AHB slave select.
	input wire logic [31:0] haddr_in, // AHB address.
	input wire logic [1:0] htrans_in, // AHB transfer type.
	input wire logic hwrite_in, // AHB write.
	input wire logic [2:0] hsize_in, // AHB size, word only.
	input wire logic [31:0] hwdata_in, // AHB write data.
	input wire logic hready_in, // AHB bus ready.
	output logic hreadyout_out, // AHB slave ready.
	output logic hresp_out, // AHB response, always OKAY.
	output logic [31:0] hrdata_out, // AHB read data.
	snp_if.host link // Serial link to the flash.
);
	snp_pkg::snp_hst_t st;
	logic [1:0] miso_s;
	logic [31:0] cmd;
	logic [23:0] row;
	logic wp;
	logic [7:0] last_rx, rx, tx;
	logic [3:0] cnt;
	logic [2:0] bit_cnt;
	logic [8:0] byte_idx;
	logic sclk, cs_n, start;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic ready, resp;
	logic [31:0] rdata;

	// Bus decode and register read mux.
	wire acc = hsel_in & hready_in & htrans_in[1];
	wire [7:0] a = haddr_in[7:0];
	wire eng_busy = st != snp_pkg::H_IDLE;
	wire [31:0] rmux = (a == snp_pkg::HR_CMD) ? cmd :
		(a == snp_pkg::HR_ROW) ? {8'h00, row} :
		(a == snp_pkg::HR_STAT) ? {16'h0000, last_rx, 7'h00, eng_busy} :
		(a == snp_pkg::HR_WP) ? {31'h0, wp} : 32'h0;
	wire [7:0] op = cmd[7:0];
	wire is_arr = (op == snp_pkg::CMD_PROG) | (op == snp_pkg::CMD_PROT)
		| (op == snp_pkg::CMD_ERASE);
	wire [8:0] rep_idx = 9'(cmd[snp_pkg::CMD_REP_LSB +: 8]) + 9'h002;
	wire [8:0] last_idx = (op == snp_pkg::CMD_GETF) ? rep_idx :
		(op == snp_pkg::CMD_SETF) ? 9'h002 : is_arr ? 9'h003 : 9'h000;
	wire [8:0] nidx = byte_idx + 9'h001;
	wire [7:0] nxt = (nidx == 9'h001) ? (is_arr ? row[23:16] :
		cmd[snp_pkg::CMD_FA_LSB +: 8]) : (nidx == 9'h002) ? (is_arr ?
		row[15:8] : cmd[snp_pkg::CMD_FD_LSB +: 8]) : (nidx == 9'h003) ?
		row[7:0] : 8'h00;
	wire tick = cnt == (snp_pkg::HALF_CYC - 4'h1);

	// AHB slave: zero wait states, writes land in the data phase.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ready <= 1'b0;
			resp <= 1'b0;
			rdata <= 32'h0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			ready <= 1'b1;
			wr_pend <= acc & hwrite_in;
			wr_addr <= a;
			if (acc && !hwrite_in) begin
				rdata <= rmux;
			end
		end
	end

	// Writable registers; a command write while busy is dropped.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd <= 32'h0;
			row <= 24'h0;
			wp <= snp_pkg::WP_RST;
			start <= 1'b0;
		end else begin
			start <= 1'b0;
			if (wr_pend && wr_addr == snp_pkg::HR_CMD && st == snp_pkg::H_IDLE
				&& !start) begin
				cmd <= hwdata_in;
				start <= 1'b1;
			end
			if (wr_pend && wr_addr == snp_pkg::HR_ROW) begin
				row <= hwdata_in[23:0];
			end
			if (wr_pend && wr_addr == snp_pkg::HR_WP) begin
				wp <= hwdata_in[0];
			end
		end
	end

	// Miso is from the flash's domain and is synchronised first.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			miso_s <= 2'h0;
		end else begin
			miso_s <= {miso_s[0], link.miso};
		end
	end

	// Frame engine: mode 0, data set while clock low, sampled on rise.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= snp_pkg::H_IDLE;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			cnt <= 4'h0;
			bit_cnt <= 3'h0;
			byte_idx <= 9'h000;
			tx <= 8'h00;
			rx <= 8'h00;
			last_rx <= 8'h00;
		end else begin
			cnt <= tick ? 4'h0 : cnt + 4'h1;
			unique case (st)
				snp_pkg::H_IDLE: begin
					cnt <= 4'h0;
					if (start) begin
						st <= snp_pkg::H_SHIFT;
						cs_n <= 1'b0;
						tx <= op;
						bit_cnt <= 3'h0;
						byte_idx <= 9'h000;
					end
				end
				snp_pkg::H_SHIFT: begin
					if (tick && !sclk) begin
						sclk <= 1'b1;
						rx <= {rx[6:0], miso_s[1]};
					end else if (tick) begin
						sclk <= 1'b0;
						bit_cnt <= bit_cnt + 3'h1;
						tx <= {tx[6:0], 1'b0};
						if (bit_cnt == 3'h7) begin
							last_rx <= rx;
							byte_idx <= nidx;
							tx <= nxt;
							if (byte_idx == last_idx) begin
								st <= snp_pkg::H_END;
							end
						end
					end
				end
				snp_pkg::H_END: begin
					cs_n <= 1'b1;
					if (tick) begin
						st <= snp_pkg::H_IDLE;
					end
				end
				default: begin
					st <= snp_pkg::H_IDLE;
				end
			endcase
		end
	end

	assign hreadyout_out = ready;
	assign hresp_out = resp;
	assign hrdata_out = rdata;
	assign link.sclk = sclk;
	assign link.cs_n = cs_n;
	assign link.mosi = tx[7];
	assign link.wp_n = wp;
endmodule // snp_host
`default_nettype wire

// ===== verification/snp_chk.sv
// Assertions on the serial link and the flash side operation outputs.
`timescale 1ns/1ps
`default_nettype none
module snp_chk (
	input wire logic core_clk_in, // Core clock.
	input wire logic rst_in, // Reset, high.
	input wire logic sclk, // Link clock.
	input wire logic cs_n, // Chip select, low.
	input wire logic op_start_out, // Operation start pulse.
	input wire logic [1:0] op_kind_out, // Operation kind.
	input wire logic [10:0] op_block_out // Operation block.
);
	logic [8:0] gap;
	logic [127:0] prot;
	wire logic top_blk = op_block_out[10:7] == 4'hF;
	wire logic prot_go = op_start_out && op_kind_out == 2'h1;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// Counts cycles since the last start and remembers protected blocks.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			gap <= 9'h1FF;
			prot <= '0;
		end else begin
			gap <= op_start_out ? 9'h000 : gap + {8'h00, gap != 9'h1FF};
			if (prot_go)
				prot[op_block_out[6:0]] <= 1'b1;
		end
	end
	// A start is a single cycle pulse.
	sequence s_pulse;
		op_start_out ##1 !op_start_out;
	endsequence
	prot_range_a: assert property (prot_go |-> top_blk)
		else $error("protect started below the top blocks");
	kind_legal_a: assert property (op_start_out |-> op_kind_out != 2'h2)
		else $error("unknown operation kind");
	busy_gap_a: assert property (op_start_out |->
		gap >= snp_pkg::OP_BUSY_CYC)
		else $error("operation started while busy");
	start_frame_a: assert property (op_start_out |->
		cs_n && $past(cs_n) && $past(cs_n, 2))
		else $error("operation started inside a frame");
	start_pulse_a: assert property (op_start_out |-> s_pulse)
		else $error("start pulse too long");
	sclk_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
		else $error("link clock runs outside a frame");
	prot_once_a: assert property (prot_go |->
		!prot[op_block_out[6:0]])
		else $error("protected block protected again");
	prot_keep_a: assert property (op_start_out && !prot_go && top_blk |->
		!prot[op_block_out[6:0]])
		else $error("protected block modified");
endmodule // snp_chk
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench joining the host controller and the flash side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
	samples_checked++; \
	if ((got) !== (ex)) begin \
		num_errors++; \
		$display("unexpected %s expected %h seen %h", nm, ex, got); \
	end \
end
module tb;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic hready, hresp, op_start;
	logic [31:0] hrdata;
	logic ecc_rep = 1'b0;
	logic [3:0] ecc_flips = 4'h0;
	logic ecc_unc = 1'b0;
	logic afail = 1'b0;
	logic [1:0] op_kind;
	logic [10:0] op_blk;
	logic pf = 1'b0;
	logic ef = 1'b0;
	int num_errors = 0;
	int samples_checked = 0;
	int num_starts = 0;
	logic [10:0] base [6] = '{11'h7E0, 11'h7C0, 11'h780, 11'h700,
		11'h600, 11'h400};
	logic [3:0] fl_t [5] = '{4'h3, 4'h4, 4'h9, 4'h0, 4'h0};
	logic [1:0] ex_t [5] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h0};
	snp_if link();
	snp_dev u_snp_dev (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.link(link), .ecc_report_in(ecc_rep), .ecc_flips_in(ecc_flips),
		.ecc_uncorr_in(ecc_unc), .array_fail_in(afail),
		.op_start_out(op_start), .op_kind_out(op_kind),
		.op_block_out(op_blk));
	snp_host u_snp_host (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
		.hrdata_out(hrdata), .link(link));
	snp_chk u_snp_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.sclk(link.sclk), .cs_n(link.cs_n), .op_start_out(op_start),
		.op_kind_out(op_kind), .op_block_out(op_blk));
	// Clock generator and start counter.
	initial forever #4 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) if (op_start === 1'b1) num_starts++;
	// Prints the counts and the verdict, then ends the run.
	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic fail_out;
		num_errors++;
		test_done;
	endtask
	// Waits for the next edge with ready high.
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge core_clk_in);
		while (hready !== 1'b1) begin
			if (++n > 100) fail_out;
			@(posedge core_clk_in);
		end
	endtask
	// One single word bus transfer.
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask
	// Writes a link command and waits until the engine is idle.
	task automatic cmd(input logic [31:0] c);
		logic [31:0] q;
		int n;
		ahb(1'b1, snp_pkg::HR_CMD, c, q);
		repeat (2) @(posedge core_clk_in);
		n = 0;
		q = 32'h00000001;
		while (q[0] !== 1'b0) begin
			if (++n > 2000) fail_out;
			ahb(1'b0, snp_pkg::HR_STAT, 32'h00000000, q);
		end
	endtask
	task automatic get(input logic [7:0] fa, input logic [7:0] rep,
		output logic [7:0] v);
		logic [31:0] q;
		cmd({rep, 8'h00, fa, snp_pkg::CMD_GETF});
		ahb(1'b0, snp_pkg::HR_STAT, 32'h00000000, q);
		v = q[15:8];
	endtask
	task automatic set(input logic [7:0] fa, input logic [7:0] fd);
		cmd({8'h00, fd, fa, snp_pkg::CMD_SETF});
	endtask
	task automatic chkf(input logic [7:0] fa, input logic [7:0] ex);
		logic [7:0] v;
		get(fa, 8'h00, v);
		`CHK("feature", ex, v)
	endtask
	// Enables writes, loads the row and issues an array command.
	task automatic launch(input logic [7:0] oc, input logic [10:0] blk);
		logic [31:0] q;
		cmd({24'h000000, snp_pkg::CMD_WREN});
		ahb(1'b1, snp_pkg::HR_ROW, {15'h0000, blk, 6'h00}, q);
		cmd({24'h000000, oc});
	endtask
	// Runs an array command, polls status and checks the outcome.
	task automatic op(input logic [7:0] oc, input logic [10:0] blk,
		input logic fl, input logic st);
		logic [7:0] v;
		logic [1:0] k;
		int n0;
		int n;
		n0 = num_starts;
		k = (oc == snp_pkg::CMD_ERASE) ? snp_pkg::OPK_ERASE :
			(oc == snp_pkg::CMD_PROT) ? snp_pkg::OPK_PROT : snp_pkg::OPK_PROG;
		launch(oc, blk);
		n = 0;
		v = 8'h01;
		while (v[0] !== 1'b0) begin
			if (++n > 20) fail_out;
			get(snp_pkg::FA_STAT, 8'h00, v);
		end
		if (oc == snp_pkg::CMD_ERASE)
			ef = fl;
		else
			pf = fl;
		`CHK("status", {4'h0, pf, ef, 2'h0}, v)
		`CHK("starts", st, 1'(num_starts - n0))
		if (st) `CHK("block", blk, op_blk)
		if (st) `CHK("kind", k, op_kind)
	endtask
	// Main sequence.
	initial begin
		logic [31:0] q;
		logic [7:0] v;
		int n;
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		chkf(snp_pkg::FA_LOCK, 8'h38);
		chkf(snp_pkg::FA_CFG, 8'h00);
		chkf(snp_pkg::FA_STAT, 8'h00);
		cmd({24'h000000, snp_pkg::CMD_WREN});
		chkf(snp_pkg::FA_STAT, 8'h02);
		set(snp_pkg::FA_STAT, 8'h00);
		chkf(snp_pkg::FA_STAT, 8'h02);
		cmd({24'h000000, snp_pkg::CMD_WRDI});
		chkf(snp_pkg::FA_STAT, 8'h00);
		$display("test defaults done");
		set(snp_pkg::FA_THR, 8'h40);
		for (int i = 0; i < 5; i++) begin
			ecc_rep <= 1'b1;
			ecc_flips <= fl_t[i];
			ecc_unc <= (i == 3);
			@(posedge core_clk_in);
			ecc_rep <= 1'b0;
			chkf(snp_pkg::FA_STAT, {2'h0, ex_t[i], 4'h0});
		end
		$display("test ecc done");
		op(snp_pkg::CMD_PROG, 11'h000, 1'b1, 1'b0);
		op(snp_pkg::CMD_ERASE, 11'h7FF, 1'b1, 1'b0);
		for (int i = 0; i < 6; i++) begin
			set(snp_pkg::FA_LOCK, {2'h0, 3'(i + 1), 3'h0});
			op(snp_pkg::CMD_ERASE, base[i], 1'b1, 1'b0);
			op(snp_pkg::CMD_PROG, base[i] - 11'h001, 1'b0, 1'b1);
		end
		set(snp_pkg::FA_LOCK, 8'h00);
		op(snp_pkg::CMD_PROG, 11'h7FF, 1'b0, 1'b1);
		afail <= 1'b1;
		op(snp_pkg::CMD_ERASE, 11'h005, 1'b1, 1'b1);
		afail <= 1'b0;
		op(snp_pkg::CMD_ERASE, 11'h005, 1'b0, 1'b1);
		$display("test lock done");
		set(snp_pkg::FA_CFG, 8'h80);
		op(snp_pkg::CMD_PROT, 11'h77F, 1'b1, 1'b0);
		chkf(snp_pkg::FA_CFG, 8'h80);
		set(snp_pkg::FA_CFG, 8'h00);
		set(snp_pkg::FA_CFG, 8'h80);
		op(snp_pkg::CMD_PROT, 11'h7D0, 1'b0, 1'b1);
		set(snp_pkg::FA_CFG, 8'h00);
		op(snp_pkg::CMD_PROG, 11'h7D0, 1'b1, 1'b0);
		op(snp_pkg::CMD_ERASE, 11'h7D0, 1'b1, 1'b0);
		n = num_starts;
		launch(snp_pkg::CMD_PROT, 11'h790);
		`CHK("starts", n, num_starts)
		cmd({24'h000000, snp_pkg::CMD_WRDI});
		$display("test protect done");
		set(snp_pkg::FA_LOCK, 8'hB8);
		ahb(1'b1, snp_pkg::HR_WP, 32'h00000000, q);
		set(snp_pkg::FA_LOCK, 8'h00);
		chkf(snp_pkg::FA_LOCK, 8'hB8);
		ahb(1'b1, snp_pkg::HR_WP, 32'h00000001, q);
		set(snp_pkg::FA_LOCK, 8'h00);
		chkf(snp_pkg::FA_LOCK, 8'h00);
		// An ECC report lands mid-stream; the last byte must show it.
		fork
			get(snp_pkg::FA_STAT, 8'h02, v);
			begin
				repeat (300) @(posedge core_clk_in);
				ecc_rep <= 1'b1;
				ecc_flips <= 4'h3;
				@(posedge core_clk_in);
				ecc_rep <= 1'b0;
			end
		join
		`CHK("live", {2'h0, 2'h1, pf, ef, 2'h0}, v)
		ecc_rep <= 1'b1;
		ecc_flips <= 4'h0;
		@(posedge core_clk_in);
		ecc_rep <= 1'b0;
		get(snp_pkg::FA_STAT, 8'h03, v);
		`CHK("stream", {4'h0, pf, ef, 2'h0}, v)
		$display("test write disable and stream done");
		test_done;
	end
endmodule // tb
`default_nettype wire
